// ==== aux_gpio.sv ====
// Auxiliary pin and control-pin GPIO logic of the codec
`timescale 1ns/1ns
module aux_gpio (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire aux_gpio_pkg::reg_req_t req_i,
  output logic [7:0]                  rdata_o,
  input  wire logic                   irq_event_i,
  input  wire logic                   spi_select_i,
  input  wire logic                   aux_pin_two_i,
  output logic                        aux_pin_two_o,
  output logic                        aux_pin_two_oe_o,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe_o,
  input  wire logic                   scl_i,
  output logic                        scl_o,
  output logic                        scl_oe_o
);
  import aux_gpio_pkg::*;

  typedef enum logic [1:0] {
    IRQ_IDLE  = 2'b00,
    IRQ_PULSE = 2'b01,
    IRQ_GAP   = 2'b11
  } irq_state_t;

  logic [7:0]       aux_ctrl;
  logic [7:0]       pin_ctrl;
  logic [2:0]       sync_a;
  logic [2:0]       sync_b;
  logic             aux_in;
  logic             sda_in;
  logic             scl_in;
  logic             spi_mode;
  logic [CNT_W-1:0] irq_cnt;
  irq_state_t       irq_state;
  logic             irq_pend;
  logic             irq_level;
  logic             flags_read;
  pin_role_t        sda_role;
  pin_role_t        scl_role;
  logic [3:0]       aux_func;
  logic             aux_gpo;
  logic             aux_gpi;

  // Two-stage synchronisers for pins and the select strap
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      spi_mode <= 1'b0;
    end else begin
      sync_a <= {aux_pin_two_i, sda_i, scl_i};
      sync_b <= sync_a;
      spi_mode <= spi_select_i;
    end
  end

  logic spi_sync;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_sync <= 1'b0;
    end else begin
      spi_sync <= spi_mode;
    end
  end

  assign aux_in     = sync_b[2];
  assign sda_in     = sync_b[1];
  assign scl_in     = sync_b[0];
  assign sda_role   = pin_role_t'(pin_ctrl[SDA_FUNC_HI:SDA_FUNC_LO]);
  assign scl_role   = pin_role_t'(pin_ctrl[SCL_FUNC_HI:SCL_FUNC_LO]);
  assign aux_func   = aux_ctrl[AUX_FUNC_HI:AUX_FUNC_LO];
  assign aux_gpo    = (aux_func == AUX_FUNC_GPO);
  assign aux_gpi    = (aux_func == AUX_FUNC_GPI);
  assign flags_read = req_i.rd && (req_i.addr == REG_INT_FLAGS);

  // Aux control register: writable bits and sensed input
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_ctrl <= AUX_CTRL_RESET;
    end else begin
      if (req_i.wr && req_i.addr == REG_AUX_TWO_CTRL) begin
        aux_ctrl[7:3] <= req_i.wdata[7:3];
        aux_ctrl[AUX_DUR_BIT] <= req_i.wdata[AUX_DUR_BIT];
      end
      aux_ctrl[AUX_IN_BIT] <= aux_gpi ? aux_in : 1'b0;
      aux_ctrl[0] <= 1'b0;
    end
  end

  // Control-pin register: fields and sensed levels
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_ctrl <= PIN_CTRL_RESET;
    end else begin
      if (req_i.wr && req_i.addr == REG_CTRL_PIN_GPIO) begin
        pin_ctrl[SDA_FUNC_HI:SDA_OUT_BIT] <= req_i.wdata[SDA_FUNC_HI:SDA_OUT_BIT];
        pin_ctrl[SCL_FUNC_HI:SCL_OUT_BIT] <= req_i.wdata[SCL_FUNC_HI:SCL_OUT_BIT];
      end
      pin_ctrl[SDA_IN_BIT] <= (spi_sync && sda_role == PIN_INPUT) ? sda_in : 1'b0;
      pin_ctrl[SCL_IN_BIT] <= (spi_sync && scl_role == PIN_INPUT) ? scl_in : 1'b0;
    end
  end

  // Interrupt pulse generator: single pulse or repeated until flags read
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_state <= IRQ_IDLE;
      irq_cnt   <= '0;
      irq_pend  <= 1'b0;
      irq_level <= 1'b0;
    end else begin
      // Event wins over a simultaneous flags read
      if (irq_event_i) begin
        irq_pend <= 1'b1;
      end else if (flags_read) begin
        irq_pend <= 1'b0;
      end
      case (irq_state)
        IRQ_IDLE: begin
          if (irq_event_i) begin
            irq_state <= IRQ_PULSE;
            irq_level <= 1'b1;
            irq_cnt   <= CNT_W'(IRQ_PULSE_CYCLES - 1);
          end
        end
        IRQ_PULSE: begin
          if (irq_cnt != '0) begin
            irq_cnt <= irq_cnt - 1'b1;
          end else if (!aux_ctrl[AUX_DUR_BIT]) begin
            irq_state <= IRQ_IDLE;
            irq_level <= 1'b0;
          end else begin
            irq_state <= IRQ_GAP;
            irq_level <= 1'b0;
            irq_cnt   <= CNT_W'(IRQ_PULSE_CYCLES - 1);
          end
        end
        IRQ_GAP: begin
          if (irq_cnt != '0) begin
            irq_cnt <= irq_cnt - 1'b1;
          end else if (irq_pend && !flags_read) begin
            irq_state <= IRQ_PULSE;
            irq_level <= 1'b1;
            irq_cnt   <= CNT_W'(IRQ_PULSE_CYCLES - 1);
          end else begin
            irq_state <= IRQ_IDLE;
          end
        end
        default: begin
          irq_state <= IRQ_IDLE;
          irq_level <= 1'b0;
        end
      endcase
    end
  end

  // Aux pin output stage
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_pin_two_o    <= 1'b0;
      aux_pin_two_oe_o <= 1'b0;
    end else begin
      if (aux_gpo) begin
        aux_pin_two_o    <= aux_ctrl[AUX_OUT_BIT];
        aux_pin_two_oe_o <= 1'b1;
      end else begin
        aux_pin_two_o    <= irq_level;
        aux_pin_two_oe_o <= (aux_func != AUX_FUNC_GPI) && (aux_func != 4'h0);
      end
    end
  end

  // Open-drain stages for SDA and SCL
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_o    <= 1'b0;
      scl_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      // SDA low for output bit 0
      sda_oe_o <= spi_sync && sda_role == PIN_OUTPUT && !pin_ctrl[SDA_OUT_BIT];
      // SCL low for output bit 0
      scl_oe_o <= spi_sync && scl_role == PIN_OUTPUT && !pin_ctrl[SCL_OUT_BIT];
    end
  end

  // Read data, registered
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd && req_i.addr == REG_AUX_TWO_CTRL) begin
      rdata_o <= aux_ctrl;
    end else if (req_i.rd && req_i.addr == REG_CTRL_PIN_GPIO) begin
      rdata_o <= pin_ctrl;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

// ==== aux_gpio_pkg.sv ====
// Package for the auxiliary pin and control-pin GPIO block
package aux_gpio_pkg;
  // Register indices (byte-wide register file, no bus)
  localparam logic [6:0] REG_AUX_TWO_CTRL  = 7'h63;
  localparam logic [6:0] REG_CTRL_PIN_GPIO = 7'h64;
  localparam logic [6:0] REG_INT_FLAGS     = 7'h60;
  // Auxiliary pin register field positions
  localparam int AUX_FUNC_HI  = 7;
  localparam int AUX_FUNC_LO  = 4;
  localparam int AUX_OUT_BIT  = 3;
  localparam int AUX_IN_BIT   = 2;
  localparam int AUX_DUR_BIT  = 1;
  // Auxiliary pin function codes
  localparam logic [3:0] AUX_FUNC_GPI = 4'h3;
  localparam logic [3:0] AUX_FUNC_GPO = 4'h4;
  // Control-pin register field positions
  localparam int SDA_FUNC_HI = 7;
  localparam int SDA_FUNC_LO = 6;
  localparam int SDA_OUT_BIT = 5;
  localparam int SDA_IN_BIT  = 4;
  localparam int SCL_FUNC_HI = 3;
  localparam int SCL_FUNC_LO = 2;
  localparam int SCL_OUT_BIT = 1;
  localparam int SCL_IN_BIT  = 0;
  // Pin role codes
  typedef enum logic [1:0] {
    PIN_UNUSED = 2'b00,
    PIN_INPUT  = 2'b01,
    PIN_OUTPUT = 2'b10
  } pin_role_t;
  // Reset values
  localparam logic [7:0] AUX_CTRL_RESET = 8'h00;
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
  // Interrupt pulse timing
  localparam int  CLK_HZ           = 25_000_000;
  localparam int  IRQ_PULSE_US     = 2000;
  localparam int  IRQ_PULSE_CYCLES = (CLK_HZ / 1_000_000) * IRQ_PULSE_US;
  localparam int  CNT_W            = 17;
  // Register write or read request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ==== aux_gpio_properties.sv ====
// Port-level properties of the aux and control-pin GPIO block
`timescale 1ns/1ns
module aux_gpio_properties (
  input wire logic                   mclk_i,
  input wire logic                   rst_i,
  input wire aux_gpio_pkg::reg_req_t req_i,
  input wire logic [7:0]             rdata_o,
  input wire logic                   spi_select_i,
  input wire logic                   aux_pin_two_o,
  input wire logic                   aux_pin_two_oe_o,
  input wire logic                   sda_o,
  input wire logic                   sda_oe_o,
  input wire logic                   scl_o,
  input wire logic                   scl_oe_o
);
  import aux_gpio_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Lone write of a register, settled SPI mode for the pin register
  sequence s_pin_wr;
    spi_select_i [*4] ##0 req_i.wr && req_i.addr == REG_CTRL_PIN_GPIO ##1 !req_i.wr;
  endsequence
  sequence s_aux_wr(logic [3:0] f);
    req_i.wr && req_i.addr == REG_AUX_TWO_CTRL && req_i.wdata[7:4] == f ##1 !req_i.wr;
  endsequence
  property p_open_drain; !sda_o && !scl_o; endproperty
  property p_spi_off; !spi_select_i [*6] |-> !sda_oe_o && !scl_oe_o; endproperty
  property p_sda_pin; s_pin_wr |=> sda_oe_o == ($past(req_i.wdata[7:5], 2) == 3'b100); endproperty
  property p_scl_pin; s_pin_wr |=> scl_oe_o == ($past(req_i.wdata[3:1], 2) == 3'b100); endproperty
  property p_aux_out;
    s_aux_wr(AUX_FUNC_GPO) |=> aux_pin_two_oe_o && aux_pin_two_o == $past(req_i.wdata[3], 2);
  endproperty
  property p_aux_in; s_aux_wr(AUX_FUNC_GPI) |=> !aux_pin_two_oe_o; endproperty
  property p_reserved; req_i.rd && req_i.addr == REG_AUX_TWO_CTRL |=> !rdata_o[0]; endproperty
  property p_in_off;
    !spi_select_i [*6] ##0 req_i.rd && req_i.addr == REG_CTRL_PIN_GPIO |=> !rdata_o[4] && !rdata_o[0];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  a_spi_off: assert property (p_spi_off) else $error("pin pulled outside spi");
  a_sda_pin: assert property (p_sda_pin) else $error("sda enable wrong");
  a_scl_pin: assert property (p_scl_pin) else $error("scl enable wrong");
  a_aux_out: assert property (p_aux_out) else $error("aux output wrong");
  a_aux_in: assert property (p_aux_in) else $error("aux driven as input");
  a_reserved: assert property (p_reserved) else $error("aux bit0 set");
  a_in_off: assert property (p_in_off) else $error("input bit outside spi");
endmodule
bind aux_gpio aux_gpio_properties u_props (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
  .rdata_o(rdata_o), .spi_select_i(spi_select_i), .aux_pin_two_o(aux_pin_two_o),
  .aux_pin_two_oe_o(aux_pin_two_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o));

// ==== codec_aux_gpio_and_control_pin_reuse_test.sv ====
// Self-checking testbench for the aux and control-pin GPIO block
`timescale 1ns/1ns
module codec_aux_gpio_and_control_pin_reuse_test;
  import aux_gpio_pkg::*;
  logic       mclk_i = 0, rst_i = 1, irq_i = 0, spi = 1, rd_d = 0;
  logic       ext_aux = 0, sda_lo = 0, scl_lo = 0;
  logic       aux_o, aux_oe, sda_o, sda_oe, scl_o, scl_oe, so, co, ao, af, se, ce;
  logic [7:0] rdata;
  logic [1:0] sf, cf;
  logic [7:0] exp_q[$];
  reg_req_t   req;
  int         err_total = 0, check_count = 0, n;
  bit [31:0]  r;
  initial forever #20 mclk_i = ~mclk_i;
  host_model host (.mclk_i(mclk_i), .req_o(req));
  aux_gpio DUT (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
    .irq_event_i(irq_i), .spi_select_i(spi), .aux_pin_two_i(aux_oe ? aux_o : ext_aux),
    .aux_pin_two_o(aux_o), .aux_pin_two_oe_o(aux_oe), .sda_i(!(sda_oe | sda_lo)),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .scl_i(!(scl_oe | scl_lo)), .scl_o(scl_o),
    .scl_oe_o(scl_oe));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.issue(1'b0, a, 8'h00);
  endtask
  // Read results compared against the oldest note
  always @(posedge mclk_i) rd_d <= req.rd;
  always @(negedge mclk_i) if (rd_d === 1'b1) chk(rdata, exp_q.pop_front());
  // Main sequence
  initial begin
    void'($urandom(32'h6d72));
    repeat (5) @(negedge mclk_i);
    rst_i = 0;
    rd(REG_AUX_TWO_CTRL, AUX_CTRL_RESET);
    rd(REG_CTRL_PIN_GPIO, PIN_CTRL_RESET);
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      sf = 2'(r[3:0] % 3);
      cf = 2'(r[7:4] % 3);
      {so, co, af, ao, ext_aux, sda_lo, scl_lo} = r[14:8];
      spi = r[15] | r[16];
      host.issue(1'b1, REG_CTRL_PIN_GPIO, {sf, so, 1'b0, cf, co, 1'b0});
      host.issue(1'b1, REG_AUX_TWO_CTRL, {af ? AUX_FUNC_GPO : AUX_FUNC_GPI, ao, 3'b000});
      repeat (6) @(negedge mclk_i);
      se = spi && sf == PIN_OUTPUT && !so;
      ce = spi && cf == PIN_OUTPUT && !co;
      chk({4'h0, sda_oe, scl_oe, sda_o, scl_o}, {4'h0, se, ce, 2'b00});
      chk({6'h0, aux_oe, aux_oe & aux_o}, {6'h0, af, af & ao});
      rd(REG_CTRL_PIN_GPIO, {sf, so, spi && sf == PIN_INPUT && !sda_lo, cf, co,
        spi && cf == PIN_INPUT && !scl_lo});
      rd(REG_AUX_TWO_CTRL, {af ? AUX_FUNC_GPO : AUX_FUNC_GPI, ao, !af && ext_aux, 2'b00});
    end
    spi = 1;
    host.issue(1'b1, REG_AUX_TWO_CTRL, 8'h20);
    repeat (3) @(negedge mclk_i);
    irq_i = 1;
    @(negedge mclk_i);
    irq_i = 0;
    n = 0;
    // Single interrupt pulse counted over a wider window
    for (int k = 0; k < 60000; k++) begin
      @(negedge mclk_i);
      if (aux_oe && aux_o) n++;
    end
    chk({7'h0, n == IRQ_PULSE_CYCLES}, 8'h01);
    summarize();
  end
endmodule

// ==== host_model.sv ====
// Host model issuing register writes and reads
`timescale 1ns/1ns
module host_model (
  input  wire logic             mclk_i,
  output aux_gpio_pkg::reg_req_t req_o
);
  import aux_gpio_pkg::*;
  initial req_o = '0;
  // One request held for a single cycle from a falling edge
  task automatic issue(input logic w, input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == REG_AUX_TWO_CTRL) v[0] = 1'b0;
    if (a == REG_CTRL_PIN_GPIO && v[7:6] == 2'b11) v[7:6] = 2'b00;
    if (a == REG_CTRL_PIN_GPIO && v[3:2] == 2'b11) v[3:2] = 2'b00;
    @(negedge mclk_i);
    req_o = '{wr: w, rd: !w, addr: a, wdata: v};
    @(negedge mclk_i);
    req_o = '0;
  endtask
endmodule
